//--- logic/rpd_regs.vh
`ifndef RPD_REGS_VH
`define RPD_REGS_VH
`define RPD_OFF_CTRL_A 12'hFE8
`define RPD_OFF_CTRL_B 12'hFE9
`define RPD_OFF_CAPTURE 12'hFEA
`define RPD_OFF_DATA 12'hFEB
`define RPD_OFF_STATUS 12'hFEC
`define RPD_ADDR_CTRL_A 14'h3FA0
`define RPD_ADDR_CTRL_B 14'h3FA4
`define RPD_ADDR_CAPTURE 14'h3FA8
`define RPD_ADDR_DATA 14'h3FAC
`define RPD_ADDR_STATUS 14'h3FB0
`define RPD_RST_CTRL_A 8'h00
`define RPD_RST_CTRL_B 8'h00
`define RPD_CLKSEL_MSB 7
`define RPD_CLKSEL_LSB 6
`define RPD_POL_BIT 5
`define RPD_SRC_MSB 4
`define RPD_SRC_LSB 3
`define RPD_NF_MSB 2
`define RPD_NF_LSB 0
`define RPD_THR_MSB 7
`define RPD_THR_LSB 4
`define RPD_RUN_BIT 3
`define RPD_EN_BIT 2
`define RPD_MODE_MSB 1
`define RPD_MODE_LSB 0
`define RPD_SRC_RISE 2'h0
`define RPD_SRC_FALL 2'h1
`define RPD_SRC_BOTH 2'h2
`define RPD_SRC_RXEND 2'h3
`define RPD_PRESC_W 12
`define RPD_NF_LIM1 16'h001B
`define RPD_NF_LIM2 16'h00DF
`define RPD_NF_LIM3 16'h01BF
`define RPD_NF_LIM4 16'h037F
`define RPD_NF_LIM5 16'h06FF
`define RPD_NF_LIM6 16'h1BFF
`define RPD_NF_LIM7 16'h37FF
`endif

//--- logic/rpd_remote_pulse_width_decoder.v
`timescale 1ns/1ps
`include "rpd_regs.vh"
module rpd_remote_pulse_width_decoder #(
   parameter NF_W = 16
) (
   input wire clk_sys,
   input wire rst,
   input wire clkEn,
   input wire remoteSignalInput,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [13:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   output wire externalInterruptThree
);
   reg [7:0] ctrlA_q;
   reg [7:0] ctrlB_q;
   reg [7:0] capture_q;
   reg [7:0] dataBuf_q;
   reg [3:0] bitCount_q;
   reg overflow_q;
   reg [7:0] counter_q;
   reg counting_q;
   reg [`RPD_PRESC_W-1:0] presc_q;
   reg sync1_q;
   reg sync2_q;
   reg filt_q;
   reg filtPrev_q;
   reg [NF_W-1:0] nfCnt_q;
   reg irq_q;
   reg rxEnded_q;
   wire [1:0] clkSel = ctrlA_q[`RPD_CLKSEL_MSB:`RPD_CLKSEL_LSB];
   wire pol = ctrlA_q[`RPD_POL_BIT];
   wire [1:0] src = ctrlA_q[`RPD_SRC_MSB:`RPD_SRC_LSB];
   wire [2:0] nfSel = ctrlA_q[`RPD_NF_MSB:`RPD_NF_LSB];
   wire [3:0] thr = ctrlB_q[`RPD_THR_MSB:`RPD_THR_LSB];
   wire enable = ctrlB_q[`RPD_EN_BIT];
   wire [1:0] mode = ctrlB_q[`RPD_MODE_MSB:`RPD_MODE_LSB];
   wire wrEn = psel & penable & pwrite;
   wire wrA = wrEn & (paddr == `RPD_ADDR_CTRL_A);
   wire wrB = wrEn & (paddr == `RPD_ADDR_CTRL_B);
   wire runWrite1 = wrB & pwdata[`RPD_RUN_BIT];
   wire runWrite0 = wrB & ~pwdata[`RPD_RUN_BIT];
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign externalInterruptThree = irq_q;

   // Two-stage synchroniser ahead of everything else
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else if (clkEn) begin
         sync1_q <= remoteSignalInput;
         sync2_q <= sync1_q;
      end
   end

   // Noise filter: level must hold for the reject window before it passes
   reg [15:0] nfLimit;
   always @* begin
      case (nfSel)
         3'h1: nfLimit = `RPD_NF_LIM1;
         3'h2: nfLimit = `RPD_NF_LIM2;
         3'h3: nfLimit = `RPD_NF_LIM3;
         3'h4: nfLimit = `RPD_NF_LIM4;
         3'h5: nfLimit = `RPD_NF_LIM5;
         3'h6: nfLimit = `RPD_NF_LIM6;
         3'h7: nfLimit = `RPD_NF_LIM7;
         default: nfLimit = 16'h0000;
      endcase
   end
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         filt_q <= 1'b0;
         nfCnt_q <= {NF_W{1'b0}};
      end else if (clkEn) begin
         if (nfSel == 3'h0) begin
            filt_q <= sync2_q;
            nfCnt_q <= {NF_W{1'b0}};
         end else if (sync2_q == filt_q) begin
            nfCnt_q <= {NF_W{1'b0}};
         end else if (nfCnt_q >= nfLimit) begin
            filt_q <= sync2_q;
            nfCnt_q <= {NF_W{1'b0}};
         end else begin
            nfCnt_q <= nfCnt_q + 1'b1;
         end
      end
   end

   // Polarity applied after filtering
   wire sig = filt_q ^ pol;
   wire sigPrev = filtPrev_q ^ pol;
   wire riseEv = enable & sig & ~sigPrev;
   wire fallEv = enable & ~sig & sigPrev;

   // Prescaler tap per clock select
   reg tick;
   always @* begin
      case (clkSel)
         2'h0: tick = (presc_q[5:0] == 6'h3F);
         2'h1: tick = (presc_q[7:0] == 8'hFF);
         2'h2: tick = (presc_q[9:0] == 10'h3FF);
         default: tick = (presc_q == 12'hFFF);
      endcase
   end

   // Measurement point per source and mode
   reg measEv;
   always @* begin
      case (src)
         `RPD_SRC_RISE: measEv = (mode == 2'h1) ? fallEv : riseEv;
         `RPD_SRC_FALL: measEv = (mode == 2'h1) ? riseEv : fallEv;
         `RPD_SRC_BOTH: measEv = riseEv | fallEv;
         default: measEv = riseEv;
      endcase
   end
   // Receive mode decides and stores on the active rise for all four mode values
   wire rxMode = (src == `RPD_SRC_RXEND);
   wire bitVal = (counter_q[7:4] >= thr);
   wire storeEv = rxMode & riseEv;
   wire ovfEv = counting_q & tick & (counter_q == 8'hFF);

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrlA_q <= `RPD_RST_CTRL_A;
         ctrlB_q <= `RPD_RST_CTRL_B;
         capture_q <= 8'h00;
         dataBuf_q <= 8'h00;
         bitCount_q <= 4'h0;
         overflow_q <= 1'b0;
         counter_q <= 8'h00;
         counting_q <= 1'b0;
         presc_q <= {`RPD_PRESC_W{1'b0}};
         filtPrev_q <= 1'b0;
         irq_q <= 1'b0;
         rxEnded_q <= 1'b0;
      end else if (clkEn) begin
         filtPrev_q <= filt_q;
         presc_q <= presc_q + 1'b1;
         irq_q <= 1'b0;
         if (wrA)
            ctrlA_q <= pwdata[7:0];
         if (wrB)
            ctrlB_q <= pwdata[7:0];
         if (!enable) begin
            irq_q <= 1'b0;
         end else if (src != `RPD_SRC_RXEND) begin
            irq_q <= (src == `RPD_SRC_RISE) ? riseEv :
               (src == `RPD_SRC_FALL) ? fallEv : (riseEv | fallEv);
         end
         if (runWrite0) begin
            counting_q <= 1'b0;
            counter_q <= 8'h00;
         end else if (runWrite1) begin
            counting_q <= 1'b1;
            counter_q <= 8'h00;
            presc_q <= {`RPD_PRESC_W{1'b0}};
            overflow_q <= 1'b0;
         end else if (ovfEv & enable) begin
            counter_q <= 8'h00;
            counting_q <= 1'b0;
            overflow_q <= 1'b1;
            irq_q <= 1'b1;
         end else if (counting_q & enable & measEv) begin
            capture_q <= counter_q;
            counter_q <= 8'h00;
            if (storeEv) begin
               dataBuf_q <= {bitVal, dataBuf_q[7:1]};
               if (rxEnded_q | (bitCount_q == 4'h8)) begin
                  bitCount_q <= 4'h1;
                  rxEnded_q <= 1'b0;
               end else begin
                  bitCount_q <= bitCount_q + 1'b1;
                  if (bitCount_q == 4'h7) begin
                     irq_q <= 1'b1;
                     rxEnded_q <= 1'b1;
                  end
               end
            end
         end else if (counting_q & tick & enable) begin
            counter_q <= counter_q + 1'b1;
         end
      end
   end

   // Reads are combinational; single-cycle access, no wait states
   always @* begin
      case (paddr)
         `RPD_ADDR_CTRL_A: prdata = {24'h000000, ctrlA_q};
         `RPD_ADDR_CTRL_B: prdata = {24'h000000, ctrlB_q[7:4], counting_q, ctrlB_q[2:0]};
         `RPD_ADDR_CAPTURE: prdata = {24'h000000, capture_q};
         `RPD_ADDR_DATA: prdata = {24'h000000, dataBuf_q};
         `RPD_ADDR_STATUS: prdata = {24'h000000, bitCount_q, 1'b0, overflow_q,
            bitVal, filt_q};
         default: prdata = 32'h00000000;
      endcase
   end
endmodule

//--- verif/rpd_checker_asserts.sv
`timescale 1ns/1ps
`include "rpd_regs.vh"
module rpd_checker (
   input wire clk_sys,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [13:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire [31:0] prdata,
   input wire externalInterruptThree
);
   reg [7:0] ctrlA_q;
   reg [7:0] ctrlB_q;
   wire acc = psel && penable;
   wire wrB = acc && pwrite && paddr == `RPD_ADDR_CTRL_B;
   wire rdA = acc && !pwrite && paddr == `RPD_ADDR_CTRL_A;
   wire rdB = acc && !pwrite && paddr == `RPD_ADDR_CTRL_B;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrlA_q <= 8'h00;
         ctrlB_q <= 8'h00;
      end else begin
         if (acc && pwrite && paddr == `RPD_ADDR_CTRL_A)
            ctrlA_q <= pwdata[7:0];
         if (wrB)
            ctrlB_q <= pwdata[7:0];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence sRun;
      wrB && pwdata[3];
   endsequence
   sequence sStatRd;
      acc && paddr == `RPD_ADDR_STATUS;
   endsequence
   a_zero_wait: assert property (pready && !pslverr)
      else $error("slave stalled or erred");
   a_upper_zero: assert property (acc |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   a_ctrla_back: assert property (rdA |-> prdata[7:0] == ctrlA_q)
      else $error("control A readback differs");
   a_ctrlb_back: assert property (rdB |-> {prdata[7:4], prdata[2:0]} == {ctrlB_q[7:4], ctrlB_q[2:0]})
      else $error("control B readback differs");
   a_stop_reads: assert property (rdB && !ctrlB_q[3] |-> !prdata[3])
      else $error("counter runs while stopped");
   a_irq_pulse: assert property (externalInterruptThree |=> !externalInterruptThree)
      else $error("request longer than one cycle");
   a_irq_gated: assert property (!ctrlB_q[2] [*3] |-> !externalInterruptThree)
      else $error("request while disabled");
   a_ovf_cleared: assert property (sRun ##3 sStatRd |-> !prdata[2])
      else $error("overflow flag kept after restart");
endmodule
bind rpd_remote_pulse_width_decoder rpd_checker i_rpd_checker (.clk_sys(clk_sys), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .externalInterruptThree(externalInterruptThree));

//--- verif/rpd_ir_source.sv
`timescale 1ns/1ps
module rpd_ir_source (
   input wire clk_sys,
   output reg rxOut
);
   initial rxOut = 1'b0;
   // Carrier already stripped, so only levels; pin latch assumed low
   task drive(input reg lvl, input integer n);
      begin
         rxOut <= lvl;
         repeat (n) @(posedge clk_sys);
      end
   endtask
endmodule

//--- verif/tb.sv
`timescale 1ns/1ps
`include "rpd_regs.vh"
module tb;
   reg clk_sys = 1'b0;
   reg rst = 1'b1;
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg [13:0] paddr = 14'h0000;
   reg [31:0] pwdata = 32'h00000000;
   wire pready, pslverr, irq, rx;
   wire [31:0] prdata;
   reg [31:0] rd;
   reg [7:0] val;
   integer fail_count = 0, comparisons = 0, seed = 32'h020E31D8, i, n, irqCount = 0;
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (irq === 1'b1) irqCount <= irqCount + 1;
   rpd_ir_source i_rpd_ir_source (.clk_sys(clk_sys), .rxOut(rx));
   rpd_remote_pulse_width_decoder #(.NF_W(16)) i_rpd_remote_pulse_width_decoder (
      .clk_sys(clk_sys), .rst(rst), .clkEn(1'b1), .remoteSignalInput(rx), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .externalInterruptThree(irq));
   task check(input [31:0] seen, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
         end
      end
   endtask
   task tally_and_finish;
      begin
         if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task apb(input w, input [13:0] a, input [7:0] d);
      begin
         @(posedge clk_sys);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= {24'h000000, d};
         @(posedge clk_sys);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge clk_sys);
            n = n + 1;
         end while (pready !== 1'b1 && n < 20);
         if (pready !== 1'b1) begin
            fail_count = fail_count + 1;
            tally_and_finish;
         end
         rd = prdata;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rdExp(input [13:0] a, input [31:0] m, input [31:0] e);
      begin
         apb(1'b0, a, 8'h00);
         check(rd & m, e);
      end
   endtask
   task waitFor(input integer target, input integer lim);
      begin
         n = 0;
         while (irqCount < target && n < lim) begin
            @(posedge clk_sys);
            n = n + 1;
         end
         if (irqCount < target) begin
            fail_count = fail_count + 1;
            tally_and_finish;
         end
      end
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      // Index five is past the map; status shows nibble >= zero threshold
      for (i = 0; i < 6; i = i + 1)
         rdExp(14'(`RPD_ADDR_CTRL_A + 4 * i), 32'hFFFFFFF7, (i == 4) ? 32'h2 : 32'h0);
      val = $random(seed);
      apb(1'b1, `RPD_ADDR_CTRL_A, val);
      rdExp(`RPD_ADDR_CTRL_A, 32'hFFFFFFFF, {24'h0, val});
      apb(1'b1, `RPD_ADDR_CAPTURE, 8'hA5);
      rdExp(`RPD_ADDR_CAPTURE, 32'hFFFFFFFF, 32'h0);
      apb(1'b1, `RPD_ADDR_CTRL_A, 8'h00);
      apb(1'b1, `RPD_ADDR_CTRL_B, 8'h0C);
      waitFor(1, 17000);
      rdExp(`RPD_ADDR_STATUS, 32'h4, 32'h4);
      rdExp(`RPD_ADDR_CTRL_B, 32'h8, 32'h0);
      apb(1'b1, `RPD_ADDR_CTRL_B, 8'h0C);
      rdExp(`RPD_ADDR_STATUS, 32'h4, 32'h0);
      apb(1'b1, `RPD_ADDR_CTRL_A, 8'h01);
      i_rpd_ir_source.drive(1'b1, 10);
      i_rpd_ir_source.drive(1'b0, 640);
      i_rpd_ir_source.drive(1'b1, 1);
      waitFor(2, 300);
      rdExp(`RPD_ADDR_CAPTURE, 32'hFC, 32'h8);
      check(irqCount, 2);
      rdExp(`RPD_ADDR_STATUS, 32'h1, 32'h1);
      i_rpd_ir_source.drive(1'b0, 100);
      // Polarity set before reception and left alone during it
      apb(1'b1, `RPD_ADDR_CTRL_A, 8'h18);
      apb(1'b1, `RPD_ADDR_CTRL_B, 8'h24);
      apb(1'b1, `RPD_ADDR_CTRL_B, 8'h2C);
      val = $random(seed);
      for (i = 0; i < 8; i = i + 1) begin
         i_rpd_ir_source.drive(1'b0, val[i] ? 2872 : 824);
         i_rpd_ir_source.drive(1'b1, 200);
      end
      check(irqCount, 3);
      rdExp(`RPD_ADDR_DATA, 32'hFF, {24'h0, val});
      rdExp(`RPD_ADDR_STATUS, 32'hF0, 32'h80);
      i_rpd_ir_source.drive(1'b0, 1000);
      i_rpd_ir_source.drive(1'b1, 200);
      rdExp(`RPD_ADDR_STATUS, 32'hF0, 32'h10);
      tally_and_finish;
   end
endmodule
